// *** hdl/bce_pkg.sv ***
// Purpose: Shared constants and types for the branch condition and address slice.
// Assumes: Single core clock, synchronous active-high reset.
// Notes:   All encodings here are local to this slice and its decoder.
package bce_pkg;
    // Branch condition selector codes from the decode stage.
    typedef enum logic [4:0] {
        BCE_C_ABOVE, BCE_C_BELOW_EQ, BCE_C_NOCARRY, BCE_C_CARRY,
        BCE_C_ZERO, BCE_C_NOT_ZERO, BCE_C_GREATER, BCE_C_LESS_EQ,
        BCE_C_GREATER_EQ, BCE_C_LESS, BCE_C_OVF, BCE_C_NO_OVF,
        BCE_C_SIGN, BCE_C_NO_SIGN, BCE_C_PAR_EVEN, BCE_C_PAR_ODD,
        BCE_C_LOOP, BCE_C_LOOP_Z, BCE_C_LOOP_NZ, BCE_C_CNT_ZERO,
        BCE_C_ALWAYS
    } bce_cond_e;

    // Operand source classes.
    typedef enum logic [1:0] {
        BCE_OP_REG, BCE_OP_IMM, BCE_OP_MEM, BCE_OP_IO
    } bce_opnd_e;

    // Segment selector codes.
    localparam logic [1:0] SEG_EXTRA = 2'h0;
    localparam logic [1:0] SEG_CODE  = 2'h1;
    localparam logic [1:0] SEG_STACK = 2'h2;
    localparam logic [1:0] SEG_DATA  = 2'h3;

    // Fields of the addressing byte (second instruction byte).
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int RM_HI   = 2;
    localparam int RM_LO   = 0;

    // Addressing mode field values.
    localparam logic [1:0] MODE_NO_DISP = 2'h0;
    localparam logic [1:0] MODE_DISP8   = 2'h1;
    localparam logic [1:0] MODE_DISP16  = 2'h2;
    localparam logic [1:0] MODE_REG     = 2'h3;
    localparam logic [2:0] RM_DIRECT    = 3'h6;

    // Datapath widths and shifts.
    localparam int WORD_W  = 16;
    localparam int PHYS_W  = 20;
    localparam int SEG_SH  = 4;
    localparam int BYTE_W  = 8;
    localparam logic [15:0] ONE_W = 16'h0001;
    localparam logic [15:0] TWO_W = 16'h0002;
endpackage : bce_pkg

// *** hdl/bce_branch_ea.sv ***
// Purpose: Branch decision, loop counting, effective and physical address forming.
// Assumes: Decoder presents one request per cycle with OP_VALID; results registered.
// Notes:   Flags pass through untouched; this slice never writes them.
//
// Functional notes
// - Above needs carry and zero clear.
// - Carry clear or set selects above-equal or below.
// - Greater uses sign xor overflow or zero.
// - Greater-equal uses sign xor overflow.
// - Single flag jumps test one flag.
// - Above/below unsigned, greater/less signed.
// - Loops count with count_reg, short relative target.
// - Software and nonmaskable interrupts skip acknowledge cycle.
// - Control instructions leave flags unchanged.
// - Immediates 8 or 16 bits, source only, no bus.
// - Register operands never start a bus cycle.
// - Memory access uses segment plus offset, 20 bits.
// - Effective address is unsigned 16-bit offset.
// - Effective address sums displacement, base, index.
// - Displacement is 8 or 16 bits.
// - Address method decoded from second byte.
// - Base is data_base_reg/frame_base_reg; index source/dest_index.
// - Frame base defaults to stack segment, overridable.
// - Indirect jumps take any 16-bit register.
// - Strings use source/data and dest/extra, auto adjust.
// - Direct ports 0-255, indirect from port_index_reg.
// - Taken branch goes to target, else next.
`timescale 1ns/1ps
module bce_branch_ea (
    input  wire logic                SYS_CLK,
    input  wire logic                SYS_RST,
    input  wire logic                OP_VALID,
    input  wire bce_pkg::bce_cond_e  COND_SEL,
    input  wire logic                IS_BRANCH,
    input  wire bce_pkg::bce_opnd_e  OPND_KIND,
    input  wire logic                IMM_WIDE,
    input  wire logic [15:0]         IMM_VALUE,
    input  wire logic [7:0]          ADDR_BYTE,
    input  wire logic [15:0]         DISP_VALUE,
    input  wire logic                SEG_OVR_EN,
    input  wire logic [1:0]          SEG_OVR_SEL,
    input  wire logic                STRING_OP,
    input  wire logic                STRING_WORD,
    input  wire logic                DIR_FLAG,
    input  wire logic                REG_INDIRECT,
    input  wire logic [15:0]         GP_REG_VALUE,
    input  wire logic                IO_INDIRECT,
    input  wire logic [7:0]          IO_PORT_IMM,
    input  wire logic                INT_SOFT,
    input  wire logic                INT_NMI,
    input  wire logic                INT_EXT,
    input  wire logic                CARRY_FLAG,
    input  wire logic                ZERO_FLAG,
    input  wire logic                SIGN_FLAG,
    input  wire logic                OVERFLOW_FLAG,
    input  wire logic                PARITY_FLAG,
    input  wire logic [15:0]         NEXT_IP,
    input  wire logic [7:0]          REL_DISP,
    input  wire logic [15:0]         COUNT_REG,
    input  wire logic [15:0]         DATA_BASE_REG,
    input  wire logic [15:0]         FRAME_BASE_REG,
    input  wire logic [15:0]         SOURCE_INDEX,
    input  wire logic [15:0]         DEST_INDEX,
    input  wire logic [15:0]         PORT_INDEX_REG,
    input  wire logic [15:0]         CODE_SEGMENT,
    input  wire logic [15:0]         DATA_SEGMENT,
    input  wire logic [15:0]         EXTRA_SEGMENT,
    input  wire logic [15:0]         STACK_SEGMENT,
    output logic                     RES_VALID,
    output logic                     BRANCH_TAKEN,
    output logic [15:0]              NEW_IP,
    output logic                     COUNT_WE,
    output logic [15:0]              COUNT_NEXT,
    output logic [15:0]              EFFECTIVE_ADDRESS,
    output logic [19:0]              PHYS_ADDR,
    output logic                     BUS_REQ,
    output logic [15:0]              IO_PORT,
    output logic                     IO_REQ,
    output logic [15:0]              SRC_INDEX_NEXT,
    output logic [15:0]              DST_INDEX_NEXT,
    output logic [19:0]              STR_DST_PHYS,
    output logic [15:0]              SRC_OPERAND,
    output logic                     INTA_CYCLE_REQ,
    output logic                     FLAGS_WE
);

    ////////////////////////////////////////////////////////////////////////////
    // Condition evaluation.
    ////////////////////////////////////////////////////////////////////////////

    // Unsigned compare term: carry or zero.
    wire        cz_any   = CARRY_FLAG | ZERO_FLAG;
    // Signed less term: sign differs from overflow.
    wire        s_lt     = SIGN_FLAG ^ OVERFLOW_FLAG;
    // Signed less-or-equal term.
    wire        s_le     = s_lt | ZERO_FLAG;
    // Count after the loop decrement.
    wire [15:0] cnt_dec  = COUNT_REG - bce_pkg::ONE_W;
    // Count reaches zero after decrement.
    wire        cnt_done = (cnt_dec == '0);
    // Count already zero before any decrement.
    wire        cnt_zero = (COUNT_REG == '0);
    // Decrementing loop selectors.
    wire        is_loop  = COND_SEL inside {bce_pkg::BCE_C_LOOP, bce_pkg::BCE_C_LOOP_Z, bce_pkg::BCE_C_LOOP_NZ};

    logic cond_true; // Selected condition result.

    // Flag decode per selector; above/below read carry, greater/less read sign xor overflow.
    always_comb begin
        unique case (COND_SEL)
            bce_pkg::BCE_C_ABOVE:      cond_true = ~cz_any;
            bce_pkg::BCE_C_BELOW_EQ:   cond_true = cz_any;
            bce_pkg::BCE_C_NOCARRY:    cond_true = ~CARRY_FLAG;
            bce_pkg::BCE_C_CARRY:      cond_true = CARRY_FLAG;
            bce_pkg::BCE_C_ZERO:       cond_true = ZERO_FLAG;
            bce_pkg::BCE_C_NOT_ZERO:   cond_true = ~ZERO_FLAG;
            bce_pkg::BCE_C_GREATER:    cond_true = ~s_le;
            bce_pkg::BCE_C_LESS_EQ:    cond_true = s_le;
            bce_pkg::BCE_C_GREATER_EQ: cond_true = ~s_lt;
            bce_pkg::BCE_C_LESS:       cond_true = s_lt;
            bce_pkg::BCE_C_OVF:        cond_true = OVERFLOW_FLAG;
            bce_pkg::BCE_C_NO_OVF:     cond_true = ~OVERFLOW_FLAG;
            bce_pkg::BCE_C_SIGN:       cond_true = SIGN_FLAG;
            bce_pkg::BCE_C_NO_SIGN:    cond_true = ~SIGN_FLAG;
            bce_pkg::BCE_C_PAR_EVEN:   cond_true = PARITY_FLAG;
            bce_pkg::BCE_C_PAR_ODD:    cond_true = ~PARITY_FLAG;
            bce_pkg::BCE_C_LOOP:       cond_true = ~cnt_done;
            bce_pkg::BCE_C_LOOP_Z:     cond_true = ~cnt_done & ZERO_FLAG;
            bce_pkg::BCE_C_LOOP_NZ:    cond_true = ~cnt_done & ~ZERO_FLAG;
            bce_pkg::BCE_C_CNT_ZERO:   cond_true = cnt_zero;
            bce_pkg::BCE_C_ALWAYS:     cond_true = 1'b1;
            default:                   cond_true = 1'b0;
        endcase
    end

    // Sign-extended short displacement keeps targets within -128..+127.
    wire [15:0] rel_ext   = {{(bce_pkg::WORD_W - bce_pkg::BYTE_W){REL_DISP[7]}}, REL_DISP};
    // Self-relative target from the next instruction.
    wire [15:0] rel_tgt   = NEXT_IP + rel_ext;
    // Indirect targets come from any general register.
    wire [15:0] br_tgt    = REG_INDIRECT ? GP_REG_VALUE : rel_tgt;
    // Branch taken only for valid branch requests with a true condition.
    wire        take      = OP_VALID & IS_BRANCH & cond_true;
    // Taken goes to target, false falls through to next instruction.
    wire [15:0] ip_d      = take ? br_tgt : NEXT_IP;

    ////////////////////////////////////////////////////////////////////////////
    // Effective address forming.
    ////////////////////////////////////////////////////////////////////////////

    // Mode and register-memory fields of the second byte.
    wire [1:0] am_mode = ADDR_BYTE[bce_pkg::MODE_HI:bce_pkg::MODE_LO];
    wire [2:0] am_rm   = ADDR_BYTE[bce_pkg::RM_HI:bce_pkg::RM_LO];
    // Direct form: no registers, displacement only.
    wire       am_dir  = (am_mode == bce_pkg::MODE_NO_DISP) && (am_rm == bce_pkg::RM_DIRECT);

    logic [15:0] base_v;  // Selected base register value.
    logic [15:0] index_v; // Selected index register value.
    logic        frame_b; // Frame base chosen.

    // Base and index choice; only the two bases and two indexes exist.
    always_comb begin
        base_v  = '0;
        index_v = '0;
        frame_b = 1'b0;
        unique case (am_rm)
            3'h0: begin base_v = DATA_BASE_REG;  index_v = SOURCE_INDEX; end
            3'h1: begin base_v = DATA_BASE_REG;  index_v = DEST_INDEX;   end
            3'h2: begin base_v = FRAME_BASE_REG; index_v = SOURCE_INDEX; frame_b = 1'b1; end
            3'h3: begin base_v = FRAME_BASE_REG; index_v = DEST_INDEX;   frame_b = 1'b1; end
            3'h4: index_v = SOURCE_INDEX;
            3'h5: index_v = DEST_INDEX;
            3'h6: begin
                if (!am_dir) begin
                    base_v  = FRAME_BASE_REG;
                    frame_b = 1'b1;
                end
            end
            3'h7: base_v = DATA_BASE_REG;
        endcase
    end

    // Short displacement sign-extended; long taken whole, as in the direct form; none in the other no-disp cases.
    wire [15:0] disp_v = (am_mode == bce_pkg::MODE_DISP8)
                         ? {{(bce_pkg::WORD_W - bce_pkg::BYTE_W){DISP_VALUE[7]}}, DISP_VALUE[7:0]}
                         : ((am_mode == bce_pkg::MODE_DISP16) || am_dir) ? DISP_VALUE : '0;
    // Unsigned 16-bit offset, wrapping within the segment.
    wire [15:0] ea_d   = disp_v + base_v + index_v;

    // Frame base defaults to the stack segment, overrides win.
    wire [1:0]  seg_dflt = frame_b ? bce_pkg::SEG_STACK : bce_pkg::SEG_DATA;
    wire [1:0]  seg_sel  = SEG_OVR_EN ? SEG_OVR_SEL : seg_dflt;
    // Selected segment value.
    wire [15:0] seg_v    = (seg_sel == bce_pkg::SEG_STACK) ? STACK_SEGMENT :
                           (seg_sel == bce_pkg::SEG_EXTRA) ? EXTRA_SEGMENT :
                           (seg_sel == bce_pkg::SEG_CODE)  ? CODE_SEGMENT  : DATA_SEGMENT;

    // Segment shifted by four, offset added, cut to 20 bits.
    function automatic logic [19:0] phys(input logic [15:0] seg, input logic [15:0] off);
        phys = {seg, {bce_pkg::SEG_SH{1'b0}}} + {{bce_pkg::SEG_SH{1'b0}}, off};
    endfunction : phys

    // String source from source_index with data segment unless overridden.
    wire [15:0] str_seg   = SEG_OVR_EN ? seg_v : DATA_SEGMENT;
    wire [15:0] mem_off   = STRING_OP ? SOURCE_INDEX : ea_d;
    wire [15:0] mem_seg   = STRING_OP ? str_seg : seg_v;
    // Step of one for bytes, two for words, sign from the direction flag.
    wire [15:0] str_step  = STRING_WORD ? bce_pkg::TWO_W : bce_pkg::ONE_W;
    wire [15:0] si_adj    = DIR_FLAG ? (SOURCE_INDEX - str_step) : (SOURCE_INDEX + str_step);
    wire [15:0] di_adj    = DIR_FLAG ? (DEST_INDEX - str_step) : (DEST_INDEX + str_step);

    // Register-mode byte means register operand, no bus cycle, except for string operations.
    wire        mem_opnd  = (OPND_KIND == bce_pkg::BCE_OP_MEM) && (STRING_OP || (am_mode != bce_pkg::MODE_REG));
    // Immediate zero-extended when only a byte wide.
    wire [15:0] imm_v     = IMM_WIDE ? IMM_VALUE : {{bce_pkg::BYTE_W{1'b0}}, IMM_VALUE[7:0]};
    // Direct port from 8-bit immediate, indirect from port_index_reg.
    wire [15:0] port_d    = IO_INDIRECT ? PORT_INDEX_REG : {{bce_pkg::BYTE_W{1'b0}}, IO_PORT_IMM};
    // Acknowledge cycle only for external maskable sources.
    wire        inta_d    = OP_VALID & INT_EXT & ~INT_SOFT & ~INT_NMI;

    ////////////////////////////////////////////////////////////////////////////
    // Result registers.
    ////////////////////////////////////////////////////////////////////////////

    // Branch and loop results.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            RES_VALID    <= 1'b0;
            BRANCH_TAKEN <= 1'b0;
            NEW_IP       <= '0;
            COUNT_WE     <= 1'b0;
            COUNT_NEXT   <= '0;
        end else begin
            RES_VALID    <= OP_VALID;
            BRANCH_TAKEN <= take;
            NEW_IP       <= ip_d;
            COUNT_WE     <= OP_VALID & IS_BRANCH & is_loop;
            COUNT_NEXT   <= cnt_dec;
        end
    end

    // Address and operand results; bus only requested for memory operands.
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            EFFECTIVE_ADDRESS <= '0;
            PHYS_ADDR         <= '0;
            BUS_REQ           <= 1'b0;
            IO_PORT           <= '0;
            IO_REQ            <= 1'b0;
            SRC_INDEX_NEXT    <= '0;
            DST_INDEX_NEXT    <= '0;
            STR_DST_PHYS      <= '0;
            SRC_OPERAND       <= '0;
            INTA_CYCLE_REQ    <= 1'b0;
            FLAGS_WE          <= 1'b0;
        end else begin
            EFFECTIVE_ADDRESS <= mem_off;
            PHYS_ADDR         <= phys(mem_seg, mem_off);
            BUS_REQ           <= OP_VALID & mem_opnd;
            IO_PORT           <= port_d;
            IO_REQ            <= OP_VALID & (OPND_KIND == bce_pkg::BCE_OP_IO);
            SRC_INDEX_NEXT    <= si_adj;
            DST_INDEX_NEXT    <= di_adj;
            STR_DST_PHYS      <= phys(EXTRA_SEGMENT, DEST_INDEX);
            SRC_OPERAND       <= (OPND_KIND == bce_pkg::BCE_OP_IMM) ? imm_v : GP_REG_VALUE;
            INTA_CYCLE_REQ    <= inta_d;
            FLAGS_WE          <= 1'b0;
        end
    end

endmodule : bce_branch_ea

// *** bench/bce_checker.sv ***
// Purpose: Port-level timing checks for the branch and address slice.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Every result lands exactly one edge after its request.
`timescale 1ns/1ps
module bce_checker (
    input wire logic               SYS_CLK,
    input wire logic               SYS_RST,
    input wire logic               OP_VALID,
    input wire logic               IS_BRANCH,
    input wire bce_pkg::bce_cond_e COND_SEL,
    input wire bce_pkg::bce_opnd_e OPND_KIND,
    input wire logic [7:0]         ADDR_BYTE,
    input wire logic               INT_SOFT,
    input wire logic               INT_NMI,
    input wire logic               CARRY_FLAG,
    input wire logic               ZERO_FLAG,
    input wire logic               RES_VALID,
    input wire logic               BRANCH_TAKEN,
    input wire logic               BUS_REQ,
    input wire logic               IO_REQ,
    input wire logic               INTA_CYCLE_REQ,
    input wire logic               FLAGS_WE
);
    // All checks share the core clock and are muted while reset is high.
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    // A branch request of one selector.
    sequence s_br(bce_pkg::bce_cond_e sel);
        OP_VALID && IS_BRANCH && COND_SEL == sel;
    endsequence
    // A memory operand that is not the register form.
    sequence s_mem;
        OP_VALID && OPND_KIND == bce_pkg::BCE_OP_MEM && ADDR_BYTE[7:6] != bce_pkg::MODE_REG;
    endsequence
    chk_valid_delay: assert property (1 |=> RES_VALID == $past(OP_VALID))
        else $error("result strobe not one cycle after request");
    chk_above_cond: assert property (s_br(bce_pkg::BCE_C_ABOVE) |=> BRANCH_TAKEN == !$past(CARRY_FLAG | ZERO_FLAG))
        else $error("above decision wrong");
    chk_carry_cond: assert property (s_br(bce_pkg::BCE_C_CARRY) |=> BRANCH_TAKEN == $past(CARRY_FLAG))
        else $error("carry decision wrong");
    chk_zero_cond: assert property (s_br(bce_pkg::BCE_C_ZERO) |=> BRANCH_TAKEN == $past(ZERO_FLAG))
        else $error("zero decision wrong");
    chk_no_branch: assert property (OP_VALID && !IS_BRANCH |=> !BRANCH_TAKEN)
        else $error("taken without branch request");
    chk_no_ack: assert property (OP_VALID && (INT_SOFT || INT_NMI) |=> !INTA_CYCLE_REQ)
        else $error("acknowledge for soft or nonmaskable source");
    chk_flags_kept: assert property (OP_VALID |=> !FLAGS_WE [*2])
        else $error("flag write seen");
    chk_reg_nobus: assert property (OP_VALID && OPND_KIND inside {bce_pkg::BCE_OP_REG, bce_pkg::BCE_OP_IMM} |=> !BUS_REQ)
        else $error("bus cycle for register or immediate");
    chk_mem_bus: assert property (s_mem |=> BUS_REQ && !IO_REQ)
        else $error("memory operand without bus cycle");
    chk_io_req: assert property (OP_VALID && OPND_KIND == bce_pkg::BCE_OP_IO |=> IO_REQ && !BUS_REQ)
        else $error("port access without port request");
endmodule : bce_checker

// *** bench/bce_biu_model.sv ***
// Purpose: Bus unit stand-in that counts the cycles the slice asks for.
// Assumes: Request outputs are one-cycle pulses per request.
// Notes:   Counts are compared by the bench at the end of the run.
`timescale 1ns/1ps
module bce_biu_model (
    input wire logic  clk,
    input wire logic  rst,
    input wire logic  bus_req,
    input wire logic  io_req,
    input wire logic  inta_req,
    output logic [15:0] mem_cycles,
    output logic [15:0] io_cycles,
    output logic [15:0] ack_cycles
);
    // Each high cycle of a request starts one access of that kind.
    always_ff @(posedge clk) begin
        if (rst) begin
            {mem_cycles, io_cycles, ack_cycles} <= '0;
        end else begin
            mem_cycles <= mem_cycles + 16'(bus_req);
            io_cycles  <= io_cycles + 16'(io_req);
            ack_cycles <= ack_cycles + 16'(inta_req);
        end
    end
endmodule : bce_biu_model

// *** bench/tb_bce_branch_ea.sv ***
// Purpose: Self-checking bench for the branch and address slice.
// Assumes: Inputs change on the falling edge, results read one edge later.
// Notes:   Expected values come from the rules.
`timescale 1ns/1ps
module tb_bce_branch_ea;
    logic SYS_CLK, SYS_RST, OP_VALID, IS_BRANCH, IMM_WIDE, SEG_OVR_EN, STRING_OP, STRING_WORD, DIR_FLAG;
    logic REG_INDIRECT, IO_INDIRECT, INT_SOFT, INT_NMI, INT_EXT, CARRY_FLAG, ZERO_FLAG, SIGN_FLAG;
    logic OVERFLOW_FLAG, PARITY_FLAG, RES_VALID, BRANCH_TAKEN, COUNT_WE, BUS_REQ, IO_REQ, INTA_CYCLE_REQ, FLAGS_WE, t;
    logic [1:0]  SEG_OVR_SEL;
    logic [7:0]  ADDR_BYTE, IO_PORT_IMM, REL_DISP;
    logic [15:0] IMM_VALUE, DISP_VALUE, GP_REG_VALUE, NEXT_IP, COUNT_REG, DATA_BASE_REG, FRAME_BASE_REG, ea;
    logic [15:0] SOURCE_INDEX, DEST_INDEX, PORT_INDEX_REG, CODE_SEGMENT, DATA_SEGMENT, EXTRA_SEGMENT;
    logic [15:0] STACK_SEGMENT, NEW_IP, COUNT_NEXT, EFFECTIVE_ADDRESS, IO_PORT, SRC_INDEX_NEXT;
    logic [15:0] DST_INDEX_NEXT, SRC_OPERAND, mem_cycles, io_cycles, ack_cycles;
    logic [19:0] PHYS_ADDR, STR_DST_PHYS, seg;
    bce_pkg::bce_cond_e COND_SEL;
    bce_pkg::bce_opnd_e OPND_KIND;
    int bad_count, samples_checked, c, f;

    bce_branch_ea bce_branch_ea_i (.*);
    bce_biu_model bce_biu_model_i (.clk(SYS_CLK), .rst(SYS_RST), .bus_req(BUS_REQ), .io_req(IO_REQ),
        .inta_req(INTA_CYCLE_REQ), .mem_cycles, .io_cycles, .ack_cycles);

    // Core clock, 4 ns period.
    initial begin
        SYS_CLK = 1'b0;
        forever #2 SYS_CLK = ~SYS_CLK;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Single-bit result comparison.
    task automatic cmp_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_bit
    // Multi-bit result comparison.
    task automatic cmp_val(input string name, input logic [19:0] exp, input logic [19:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_val
    // Holds the request for one edge; back-to-back calls keep the strobe up.
    task automatic issue();
        OP_VALID = 1'b1;
        @(negedge SYS_CLK);
        cmp_bit("res_valid", 1'b1, RES_VALID);
    endtask : issue
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    // Decision of every flag condition, indexed by selector code.
    function automatic logic exp_take(input int sel, input logic [4:0] fl);
        logic cf, zf, sf, ovf, pf, sx;
        logic [15:0] v;
        {cf, zf, sf, ovf, pf} = fl;
        sx = sf ^ ovf;
        v = {!pf, pf, !sf, sf, !ovf, ovf, sx, !sx, sx | zf, !(sx | zf), !zf, zf, cf, !cf, cf | zf, !(cf | zf)};
        return v[sel];
    endfunction : exp_take
    // Offset from addressing byte fields, with 8-bit displacement sign-extended.
    function automatic logic [15:0] exp_ea(input logic [1:0] md, input logic [2:0] rm);
        logic [15:0] b [8];
        logic [15:0] d;
        b = '{DATA_BASE_REG + SOURCE_INDEX, DATA_BASE_REG + DEST_INDEX, FRAME_BASE_REG + SOURCE_INDEX,
              FRAME_BASE_REG + DEST_INDEX, SOURCE_INDEX, DEST_INDEX, FRAME_BASE_REG, DATA_BASE_REG};
        d = (md == 2'h1) ? {{8{DISP_VALUE[7]}}, DISP_VALUE[7:0]} : (md == 2'h2) ? DISP_VALUE : 16'h0000;
        if (md == 2'h0 && rm == 3'h6) return DISP_VALUE;
        return b[rm] + d;
    endfunction : exp_ea
    // Loop selector case: count, zero flag and expected decision.
    task automatic loop_case(input bce_pkg::bce_cond_e cs, input logic [15:0] cnt, input logic zf, input logic tk);
        COND_SEL = cs;
        COUNT_REG = cnt;
        ZERO_FLAG = zf;
        issue();
        cmp_bit("loop_taken", tk, BRANCH_TAKEN);
        cmp_bit("count_we", cs != bce_pkg::BCE_C_CNT_ZERO, COUNT_WE);
        cmp_val("count_next", {4'h0, cnt - 16'h0001}, 20'(COUNT_NEXT));
        cmp_val("loop_ip", {4'h0, tk ? NEXT_IP + 16'hff80 : NEXT_IP}, 20'(NEW_IP));
    endtask : loop_case

    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard: a clean run takes about 600 cycles.
    initial begin
        repeat (3000) @(posedge SYS_CLK);
        bad_count++;
        $display("ERROR watchdog expected finish seen hang");
        report_and_stop();
    end

    // Main sequence.
    initial begin
        {bad_count, samples_checked} = '0;
        SYS_RST = 1'b1;
        {OP_VALID, IS_BRANCH, IMM_WIDE, SEG_OVR_EN, SEG_OVR_SEL, STRING_OP, STRING_WORD, DIR_FLAG, REG_INDIRECT,
         IO_INDIRECT, INT_SOFT, INT_NMI, INT_EXT, CARRY_FLAG, ZERO_FLAG, SIGN_FLAG, OVERFLOW_FLAG, PARITY_FLAG,
         REL_DISP, COUNT_REG, ADDR_BYTE} = '0;
        {IMM_VALUE, DISP_VALUE, GP_REG_VALUE, NEXT_IP, IO_PORT_IMM} = {16'hbeef, 16'h1080, 16'hc0de, 16'h0100, 8'hff};
        {DATA_BASE_REG, FRAME_BASE_REG, SOURCE_INDEX, DEST_INDEX} = {16'h1111, 16'hf000, 16'h2000, 16'h0300};
        {PORT_INDEX_REG, CODE_SEGMENT, DATA_SEGMENT} = {16'hffff, 16'h0100, 16'h1234};
        {EXTRA_SEGMENT, STACK_SEGMENT} = {16'h0abc, 16'hfff0};
        COND_SEL = bce_pkg::BCE_C_ABOVE;
        OPND_KIND = bce_pkg::BCE_OP_REG;
        repeat (20) @(negedge SYS_CLK);
        SYS_RST = 1'b0;
        @(negedge SYS_CLK);
        cmp_bit("idle_valid", 1'b0, RES_VALID);
        // Every flag condition against every flag pattern, targets at both range ends.
        IS_BRANCH = 1'b1;
        for (c = 0; c < 16; c++) begin
            for (f = 0; f < 32; f++) begin
                COND_SEL = bce_pkg::bce_cond_e'(c);
                {CARRY_FLAG, ZERO_FLAG, SIGN_FLAG, OVERFLOW_FLAG, PARITY_FLAG} = 5'(f);
                REL_DISP = f[0] ? 8'h80 : 8'h7f;
                issue();
                t = exp_take(c, 5'(f));
                cmp_bit("taken", t, BRANCH_TAKEN);
                cmp_val("new_ip", {4'h0, t ? NEXT_IP + {{8{REL_DISP[7]}}, REL_DISP} : NEXT_IP}, 20'(NEW_IP));
            end
        end
        REL_DISP = 8'h80;
        loop_case(bce_pkg::BCE_C_LOOP, 16'h0001, 1'b0, 1'b0);
        loop_case(bce_pkg::BCE_C_LOOP, 16'h0002, 1'b0, 1'b1);
        loop_case(bce_pkg::BCE_C_LOOP_Z, 16'h0005, 1'b0, 1'b0);
        loop_case(bce_pkg::BCE_C_LOOP_Z, 16'h0005, 1'b1, 1'b1);
        loop_case(bce_pkg::BCE_C_LOOP_NZ, 16'h0005, 1'b0, 1'b1);
        loop_case(bce_pkg::BCE_C_CNT_ZERO, 16'h0000, 1'b0, 1'b1);
        // Every mode and rm code; one stack-relative case carries an override.
        IS_BRANCH = 1'b0;
        OPND_KIND = bce_pkg::BCE_OP_MEM;
        for (c = 0; c < 32; c++) begin
            ADDR_BYTE = {c[4:3], 3'h0, c[2:0]};
            SEG_OVR_EN = (c == 10);
            issue();
            ea = exp_ea(c[4:3], c[2:0]);
            seg = {SEG_OVR_EN ? EXTRA_SEGMENT : (c[2:1] == 2'h1 || (c[2:0] == 6 && c[4:3] != 0))
                ? STACK_SEGMENT : DATA_SEGMENT, 4'h0};
            cmp_bit("bus_req", c[4:3] != 2'h3, BUS_REQ);
            if (c[4:3] != 2'h3) begin
                cmp_val("ea", 20'(ea), 20'(EFFECTIVE_ADDRESS));
                cmp_val("phys", seg + 20'(ea), PHYS_ADDR);
            end
        end
        // String steps of both widths and directions.
        {SEG_OVR_EN, ADDR_BYTE, STRING_OP} = {1'b0, 8'h00, 1'b1};
        for (c = 0; c < 4; c++) begin
            {STRING_WORD, DIR_FLAG} = 2'(c);
            issue();
            ea = STRING_WORD ? 16'h0002 : 16'h0001;
            cmp_val("src_next", 20'(DIR_FLAG ? SOURCE_INDEX - ea : SOURCE_INDEX + ea), 20'(SRC_INDEX_NEXT));
            cmp_val("dst_next", 20'(DIR_FLAG ? DEST_INDEX - ea : DEST_INDEX + ea), 20'(DST_INDEX_NEXT));
            cmp_val("dst_phys", {EXTRA_SEGMENT, 4'h0} + 20'(DEST_INDEX), STR_DST_PHYS);
            cmp_val("src_phys", {DATA_SEGMENT, 4'h0} + 20'(SOURCE_INDEX), PHYS_ADDR);
        end
        // Immediates, ports and a register-held jump target.
        {STRING_OP, IMM_WIDE} = 2'b01;
        OPND_KIND = bce_pkg::BCE_OP_IMM;
        issue();
        cmp_val("imm_word", 20'h0beef, 20'(SRC_OPERAND));
        IMM_WIDE = 1'b0;
        issue();
        cmp_val("imm_byte", 20'h000ef, 20'(SRC_OPERAND));
        OPND_KIND = bce_pkg::BCE_OP_IO;
        issue();
        cmp_val("port_direct", 20'h000ff, 20'(IO_PORT));
        IO_INDIRECT = 1'b1;
        issue();
        cmp_val("port_indirect", 20'h0ffff, 20'(IO_PORT));
        {IS_BRANCH, REG_INDIRECT} = 2'b11;
        OPND_KIND = bce_pkg::BCE_OP_REG;
        COND_SEL = bce_pkg::BCE_C_ALWAYS;
        issue();
        cmp_val("reg_target", 20'h0c0de, 20'(NEW_IP));
        // Each combination of interrupt sources.
        {IS_BRANCH, REG_INDIRECT} = 2'b00;
        for (c = 0; c < 8; c++) begin
            {INT_SOFT, INT_NMI, INT_EXT} = 3'(c);
            issue();
            cmp_bit("ack_cycle", c == 1, INTA_CYCLE_REQ);
        end
        OP_VALID = 1'b0;
        repeat (2) @(negedge SYS_CLK);
        cmp_val("mem_cycles", 20'h0001c, 20'(mem_cycles));
        cmp_val("io_cycles", 20'h00002, 20'(io_cycles));
        cmp_val("ack_cycles", 20'h00001, 20'(ack_cycles));
        report_and_stop();
    end
endmodule : tb_bce_branch_ea

bind bce_branch_ea bce_checker bce_checker_i (.*);
